// file: i2clk_pkg.sv
// Constants, types and register map shared by both ends of the link
// Summary of operation
// (RULE1) Burst write advances pointer, except register zero
// (RULE2) Register address acked only when valid
// (RULE3) Access begins start, target address, write bit
// (RULE4) Burst write repeats data byte plus ack
// (RULE5) Read uses repeated start, read bit, nak
// (RULE6) Burst read: controller acks all but last
// (RULE7) Ack holds SDA low over ninth pulse
// (RULE8) Nak leaves SDA released over ninth pulse
// (RULE9) Writes to locked fields leave them unchanged
// (RULE10) Only cleared mask bits may change lock
// (RULE11) Code 0xaa locks unmasked functions
// (RULE12) Code 0x55 unlocks unmasked functions
// (RULE13) Software clears masks, then writes unlock codes
// (RULE14) All unlocked reads password registers as zero
// (RULE15) Power-up defaults come from programmed values
// (RULE16) Target answers to address 0x50
// (RULE17) Password read returns lock bit per function
// (RULE18) Other password codes change no lock state
// (RULE19) Burst read advances pointer like writes
// (RULE20) After address nak, data ignored until start
`default_nettype none
package i2clk_pkg;
	// ----------------------------------------
	// Link addressing and register map
	// ----------------------------------------
	localparam logic [6:0] TARGET_ADDR = 7'h50;
	localparam logic [7:0] REG_ZERO = 8'h00;
	localparam logic [7:0] REG_FIXED = 8'h01;
	localparam logic [7:0] PROT_BASE = 8'h10;
	localparam logic [7:0] PROT_COUNT = 8'h18;
	localparam logic [7:0] MASK_A = 8'h87;
	localparam logic [7:0] PW_A = 8'h8a;
	localparam logic [7:0] LAST_REG = 8'h8c;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] CODE_LOCK = 8'haa;
	localparam logic [7:0] CODE_UNLOCK = 8'h55;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------
	// Controller command port
	// ----------------------------------------
	localparam logic [1:0] HC_CMD = 2'h0;
	localparam logic [1:0] HC_TXDATA = 2'h1;
	localparam logic [1:0] HC_RXDATA = 2'h2;
	localparam int ST_BUSY = 0;
	localparam int ST_NAK = 1;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_START = 3'h1,
		OP_STOP = 3'h2,
		OP_SEND = 3'h3,
		OP_RECV_ACK = 3'h4,
		OP_RECV_NAK = 3'h5
	} i2clk_op_e;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCL_PERIOD_NS = 320;
	localparam int QUARTER_CYC = (SCL_PERIOD_NS / (4 * CLK_PERIOD_NS)) < 1 ?
		1 : SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage
`default_nettype wire

// file: i2clk_if.sv
// Two-wire link between controller and target, open-drain resolution
`default_nettype none
interface i2clk_if;
	logic scl_oe_host;
	logic scl_out_host;
	logic sda_oe_host;
	logic sda_out_host;
	logic sda_oe_tgt;
	logic sda_out_tgt;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups: any enabled low driver wins
	assign scl = !(scl_oe_host && !scl_out_host);
	assign sda = !((sda_oe_host && !sda_out_host) ||
		(sda_oe_tgt && !sda_out_tgt));

	modport target(input scl, sda, output sda_oe_tgt, sda_out_tgt);
	modport host(input sda, output scl_oe_host, scl_out_host,
		sda_oe_host, sda_out_host);
endinterface
`default_nettype wire

// file: i2clk_target.sv
// Two-wire target with register file and function locking
`default_nettype none
module i2clk_target #(
	parameter logic [7:0] OTP_DEFAULT = 8'h00,
	parameter logic [7:0] OTP_FIXED = 8'h00,
	parameter logic [23:0] OTP_LOCK = 24'h000000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link
	i2clk_if.target link,
	// Lock state to protected functions
	output logic [23:0] lock_state,
	output logic busy
);
	import i2clk_pkg::*;

	typedef enum logic [6:0] {
		T_IDLE = 7'b0000001,
		T_DEV = 7'b0000010,
		T_REG = 7'b0000100,
		T_WR = 7'b0001000,
		T_TX = 7'b0010000,
		T_RACK = 7'b0100000,
		T_SKIP = 7'b1000000
	} i2clk_tstate_e;

	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;

	always_ff @(posedge clock) begin
		if (rst) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], link.scl};
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign scl_rise = scl_s && !scl_prev_reg;
	assign scl_fall = !scl_s && scl_prev_reg;
	assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_cond = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

	// ----------------------------------------
	// Byte engine state
	// ----------------------------------------
	i2clk_tstate_e state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic ack_phase_reg;
	logic go_reg;
	logic rw_reg;
	logic more_reg;
	logic sda_oe_reg;
	logic sda_out_reg;
	logic busy_reg;

	logic [7:0] regs [0:LAST_REG];
	logic [7:0] mask_reg [0:2];
	logic [23:0] lock_reg;

	logic byte_done, wr_en, addr_ok, prot_hit, prot_locked;
	logic [7:0] ptr_next, prot_idx, rdata;

	assign byte_done = scl_fall && cnt_reg == BITS_PER_BYTE && !ack_phase_reg;
	assign wr_en = state_reg == T_WR && byte_done;
	assign addr_ok = shift_reg <= LAST_REG; // RULE2
	assign ptr_next = (ptr_reg == REG_ZERO) ? ptr_reg : ptr_reg + 8'h01; // RULE1
	assign prot_idx = ptr_reg - PROT_BASE;
	assign prot_hit = ptr_reg >= PROT_BASE && prot_idx < PROT_COUNT;
	assign prot_locked = prot_hit && lock_reg[prot_idx[4:0]];

	// ----------------------------------------
	// Read data mux
	// ----------------------------------------
	always_comb begin
		rdata = 8'h00;
		if (ptr_reg == REG_FIXED) begin
			rdata = OTP_FIXED; // RULE15
		end else if (ptr_reg <= LAST_REG) begin
			rdata = regs[ptr_reg];
		end
		for (int k = 0; k < 3; k++) begin
			if (ptr_reg == MASK_A + 8'(k)) begin
				rdata = mask_reg[k];
			end
			if (ptr_reg == PW_A + 8'(k)) begin
				rdata = lock_reg[8*k +: 8]; // RULE17 RULE14
			end
		end
	end

	// ----------------------------------------
	// Protocol state machine
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= T_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			ack_phase_reg <= 1'b0;
			go_reg <= 1'b0;
			rw_reg <= 1'b0;
			more_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (start_cond) begin
			// Repeated start keeps the pointer for the read phase
			state_reg <= T_DEV; // RULE3 RULE5
			cnt_reg <= 4'h0;
			ack_phase_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (stop_cond) begin
			state_reg <= T_IDLE;
			cnt_reg <= 4'h0;
			ack_phase_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			case (state_reg)
			T_DEV, T_REG, T_WR: begin
				if (scl_rise && cnt_reg != BITS_PER_BYTE) begin
					shift_reg <= {shift_reg[6:0], sda_s};
					cnt_reg <= cnt_reg + 4'h1;
				end
				if (byte_done) begin
					ack_phase_reg <= 1'b1;
					if (state_reg == T_DEV) begin
						go_reg <= shift_reg[7:1] == TARGET_ADDR; // RULE16
						sda_oe_reg <= shift_reg[7:1] == TARGET_ADDR; // RULE7
						rw_reg <= shift_reg[0];
					end else if (state_reg == T_REG) begin
						go_reg <= addr_ok;
						sda_oe_reg <= addr_ok; // RULE2 RULE8
						if (addr_ok) begin
							ptr_reg <= shift_reg;
						end
					end else begin
						go_reg <= 1'b1;
						sda_oe_reg <= 1'b1; // RULE4
						ptr_reg <= ptr_next; // RULE1
					end
				end else if (scl_fall && ack_phase_reg) begin
					ack_phase_reg <= 1'b0;
					cnt_reg <= 4'h0;
					sda_oe_reg <= 1'b0;
					if (!go_reg) begin
						state_reg <= T_SKIP; // RULE20
					end else if (state_reg == T_DEV && rw_reg) begin
						state_reg <= T_TX;
						tx_reg <= rdata;
						sda_oe_reg <= !rdata[7];
					end else if (state_reg == T_DEV) begin
						state_reg <= T_REG;
					end else begin
						state_reg <= T_WR;
					end
				end
			end
			T_TX: begin
				if (scl_rise) begin
					cnt_reg <= cnt_reg + 4'h1;
				end
				if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
					sda_oe_reg <= 1'b0; // RULE8
					state_reg <= T_RACK;
					ptr_reg <= ptr_next; // RULE19
				end else if (scl_fall) begin
					tx_reg <= {tx_reg[6:0], 1'b0};
					sda_oe_reg <= !tx_reg[6];
				end
			end
			T_RACK: begin
				if (scl_rise) begin
					more_reg <= !sda_s; // RULE6
				end
				if (scl_fall) begin
					cnt_reg <= 4'h0;
					if (more_reg) begin
						state_reg <= T_TX;
						tx_reg <= rdata;
						sda_oe_reg <= !rdata[7];
					end else begin
						state_reg <= T_SKIP; // RULE5
					end
				end
			end
			T_IDLE, T_SKIP: begin
				sda_oe_reg <= 1'b0;
			end
			default: begin
				state_reg <= T_IDLE;
				sda_oe_reg <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Power-up values stand in for the programmed memory contents
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i <= int'(LAST_REG); i++) begin
				regs[i] <= OTP_DEFAULT; // RULE15
			end
		end else if (wr_en && ptr_reg <= LAST_REG && !prot_locked &&
			ptr_reg != REG_FIXED) begin // RULE9
			regs[ptr_reg] <= shift_reg;
		end
	end

	// ----------------------------------------
	// Lock masks and lock state
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int k = 0; k < 3; k++) begin
				mask_reg[k] <= MASK_RESET;
			end
			lock_reg <= OTP_LOCK; // RULE15
		end else if (wr_en) begin
			for (int k = 0; k < 3; k++) begin
				if (ptr_reg == MASK_A + 8'(k)) begin
					mask_reg[k] <= shift_reg;
				end
				// Masked bits keep their lock state either way
				if (ptr_reg == PW_A + 8'(k) && shift_reg == CODE_LOCK) begin
					lock_reg[8*k +: 8] <= lock_reg[8*k +: 8] |
						~mask_reg[k]; // RULE11 RULE10
				end else if (ptr_reg == PW_A + 8'(k) &&
					shift_reg == CODE_UNLOCK) begin
					lock_reg[8*k +: 8] <= lock_reg[8*k +: 8] &
						mask_reg[k]; // RULE12 RULE10
				end
				// RULE18
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			sda_out_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
			busy_reg <= state_reg != T_IDLE;
		end
	end

	assign link.sda_oe_tgt = sda_oe_reg;
	assign link.sda_out_tgt = sda_out_reg;
	assign lock_state = lock_reg;
	assign busy = busy_reg;
endmodule
`default_nettype wire

// file: i2clk_host.sv
// Two-wire controller driven by primitive commands from software
`default_nettype none
module i2clk_host #(
	parameter int QUARTER = i2clk_pkg::QUARTER_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link
	i2clk_if.host link,
	// Command port
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	import i2clk_pkg::*;

	// ----------------------------------------
	// Data line synchroniser
	// ----------------------------------------
	logic [1:0] sda_sync_reg;
	always_ff @(posedge clock) begin
		if (rst) begin
			sda_sync_reg <= 2'h3;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
		end
	end

	// ----------------------------------------
	// Bit engine: four quarters per bit
	// ----------------------------------------
	i2clk_op_e op_reg;
	logic busy_reg, nak_reg;
	logic [7:0] tx_data_reg, rx_data_reg, shift_reg, rdata_reg;
	logic [7:0] qcnt_reg;
	logic [1:0] quarter_reg;
	logic [3:0] bit_reg;
	logic scl_oe_reg, sda_oe_reg;
	logic tick, bit_val, is_byte;

	assign tick = busy_reg && qcnt_reg == 8'(QUARTER - 1);
	assign is_byte = op_reg == OP_SEND || op_reg == OP_RECV_ACK ||
		op_reg == OP_RECV_NAK;

	always_comb begin
		bit_val = 1'b1;
		if (op_reg == OP_SEND && bit_reg != BITS_PER_BYTE) begin
			bit_val = shift_reg[7];
		end else if (op_reg == OP_RECV_ACK && bit_reg == BITS_PER_BYTE) begin
			bit_val = 1'b0; // RULE6 RULE7
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			op_reg <= OP_NONE;
			busy_reg <= 1'b0;
			nak_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			rx_data_reg <= 8'h00;
			shift_reg <= 8'h00;
			qcnt_reg <= 8'h00;
			quarter_reg <= 2'h0;
			bit_reg <= 4'h0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (!busy_reg) begin
			if (wr && addr == HC_TXDATA) begin
				tx_data_reg <= wdata;
			end
			if (wr && addr == HC_CMD && wdata[2:0] >= 3'(OP_START) &&
				wdata[2:0] <= 3'(OP_RECV_NAK)) begin
				op_reg <= i2clk_op_e'(wdata[2:0]);
				busy_reg <= 1'b1;
				shift_reg <= tx_data_reg;
				qcnt_reg <= 8'h00;
				quarter_reg <= 2'h0;
				bit_reg <= 4'h0;
				scl_oe_reg <= 1'b1;
			end
		end else if (!tick) begin
			qcnt_reg <= qcnt_reg + 8'h01;
		end else begin
			qcnt_reg <= 8'h00;
			quarter_reg <= quarter_reg + 2'h1;
			case (quarter_reg)
			2'h0: begin
				if (op_reg == OP_START) begin
					sda_oe_reg <= 1'b0;
				end else if (op_reg == OP_STOP) begin
					sda_oe_reg <= 1'b1;
				end else begin
					sda_oe_reg <= !bit_val; // RULE7 RULE8
				end
			end
			2'h1: begin
				scl_oe_reg <= 1'b0;
			end
			2'h2: begin
				if (op_reg == OP_START) begin
					sda_oe_reg <= 1'b1; // RULE3 RULE5
				end else if (op_reg == OP_STOP) begin
					sda_oe_reg <= 1'b0; // RULE4 RULE6
				end
			end
			default: begin
				// Sample late in the high phase to cover target latency
				if (is_byte && bit_reg != BITS_PER_BYTE) begin
					shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
					bit_reg <= bit_reg + 4'h1;
					scl_oe_reg <= 1'b1;
				end else begin
					busy_reg <= 1'b0;
					if (op_reg == OP_SEND) begin
						nak_reg <= sda_sync_reg[1]; // RULE8
					end else if (is_byte) begin
						rx_data_reg <= shift_reg;
					end
				end
			end
			endcase
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (rd) begin
			case (addr)
			HC_CMD: rdata_reg <= {6'h00, nak_reg, busy_reg};
			HC_TXDATA: rdata_reg <= tx_data_reg;
			HC_RXDATA: rdata_reg <= rx_data_reg;
			default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign link.scl_oe_host = scl_oe_reg;
	assign link.scl_out_host = 1'b0;
	assign link.sda_oe_host = sda_oe_reg;
	assign link.sda_out_host = 1'b0;
	assign rdata = rdata_reg;
endmodule
`default_nettype wire

// file: i2clk_chk.sv
// Checker for the target side of the two-wire link
`default_nettype none
module i2clk_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_oe_tgt
);
	timeunit 1ns;
	timeprecision 1ns;
	import i2clk_pkg::*;

	// ----------------------------------------
	// Frame tracking
	// ----------------------------------------
	logic scl_q, sda_q, addr_ok, wr_mode, nakd;
	logic [3:0] bitcnt;
	logic [1:0] bidx;
	logic [7:0] shreg;
	wire logic start = scl && scl_q && sda_q && !sda;
	wire logic stop = scl && scl_q && !sda_q && sda;
	wire logic rise9 = scl && !scl_q && bitcnt == 4'h8;

	always_ff @(posedge clock) begin
		scl_q <= rst | scl;
		sda_q <= rst | sda;
	end

	// Byte index saturates: all data bytes look alike
	always_ff @(posedge clock) begin
		if (rst || start || stop) begin
			bitcnt <= 4'h0;
			bidx <= 2'h0;
			nakd <= 1'b0;
			addr_ok <= 1'b0;
		end else if (scl && !scl_q) begin
			shreg <= {shreg[6:0], sda};
			bitcnt <= rise9 ? 4'h0 : bitcnt + 4'h1;
			if (rise9 && bidx != 2'h2)
				bidx <= bidx + 2'h1;
			if (rise9 && bidx == 2'h0) begin
				addr_ok <= shreg[7:1] == TARGET_ADDR;
				wr_mode <= !shreg[0];
			end
			if (rise9 && bidx == 2'h1 && addr_ok && wr_mode
				&& shreg > LAST_REG)
				nakd <= 1'b1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_tgt_stable: assert property (
		scl && scl_q |-> $stable(sda_oe_tgt))
		else $error("target moved sda while scl high");
	a_drive_low: assert property (
		$rose(sda_oe_tgt) |-> !$past(scl))
		else $error("target began driving with scl high");
	a_drive_bound: assert property (
		$rose(sda_oe_tgt) |-> ##[1:200] !sda_oe_tgt)
		else $error("target never released sda");
	a_addr_ack: assert property (
		rise9 && bidx == 2'h0 && shreg[7:1] == TARGET_ADDR
		|-> ##1 sda_oe_tgt)
		else $error("own address not acknowledged");
	a_addr_nak: assert property (
		rise9 && bidx == 2'h0 && shreg[7:1] != TARGET_ADDR
		|-> ##1 !sda_oe_tgt)
		else $error("foreign address acknowledged");
	a_reg_ack: assert property (
		rise9 && bidx == 2'h1 && addr_ok && wr_mode
		&& shreg <= LAST_REG |-> ##1 sda_oe_tgt)
		else $error("valid register address not acknowledged");
	a_reg_nak: assert property (
		rise9 && bidx == 2'h1 && addr_ok && wr_mode
		&& shreg > LAST_REG |-> ##1 !sda_oe_tgt)
		else $error("invalid register address acknowledged");
	a_data_ack: assert property (
		rise9 && bidx == 2'h2 && addr_ok && wr_mode && !nakd
		|-> ##1 sda_oe_tgt)
		else $error("written data byte not acknowledged");
	a_quiet_nak: assert property (
		nakd |-> !sda_oe_tgt)
		else $error("target drove sda after register refusal");
endmodule
`default_nettype wire

// file: test_i2c_target_access_with_locking.sv
// Testbench: controller and target joined over the two-wire link
`default_nettype none
module test_i2c_target_access_with_locking;
	timeunit 1ns;
	timeprecision 1ns;
	import i2clk_pkg::*;

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam logic [7:0] OTP_DEF = 8'h5a;
	localparam logic [7:0] OTP_FX = 8'h3c;
	localparam logic [23:0] OTP_LK = 24'h00000f;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic chk = 1'b0;
	logic chk_q = 1'b0;
	logic [7:0] rdata, st;
	logic [7:0] lfsr = 8'h13;
	logic [7:0] wbuf [4];
	logic [7:0] ebuf [4];
	logic [7:0] exp_q [$];
	logic [23:0] lock_state;
	logic tgt_busy;
	logic tchk = 1'b0;
	logic tchk_q = 1'b0;
	logic [24:0] texp_q [$];
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;

	i2clk_if link ();
	i2clk_host i_i2clk_host (.clock(clock), .rst(rst), .link(link),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	i2clk_target #(.OTP_DEFAULT(OTP_DEF), .OTP_FIXED(OTP_FX),
		.OTP_LOCK(OTP_LK)) i_i2clk_target (.clock(clock),
		.rst(rst), .link(link), .lock_state(lock_state),
		.busy(tgt_busy));
	i2clk_chk i_i2clk_chk (.clock(clock), .rst(rst), .scl(link.scl),
		.sda(link.sda), .sda_oe_tgt(link.sda_oe_tgt));

	always #20 clock = ~clock;

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic close_out;
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
		check_count++;
		if (got !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask

	task automatic cmp25(input logic [24:0] got, input logic [24:0] e);
		check_count++;
		if (got !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask

	// Read data stand one cycle only, so the note is taken there
	always @(posedge clock) begin
		chk_q <= chk;
		if (chk_q)
			cmp8(rdata, exp_q.pop_front());
	end

	// Target busy and lock state are levels, looked at on request
	always @(posedge clock) begin
		tchk_q <= tchk;
		if (tchk_q)
			cmp25({tgt_busy, lock_state}, texp_q.pop_front());
	end

	// Whole run is some 8000 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			close_out();
		end
	end

	// ----------------------------------------
	// Command port and transfers
	// ----------------------------------------
	function automatic logic [7:0] next_rand(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [1:0] a, input logic c,
		input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		chk <= c;
		if (c)
			exp_q.push_back(e);
		@(posedge clock);
		rd <= 1'b0;
		chk <= 1'b0;
		@(posedge clock);
		st = rdata;
	endtask

	task automatic note_tgt(input logic b, input logic [23:0] l);
		@(posedge clock);
		tchk <= 1'b1;
		texp_q.push_back({b, l});
		@(posedge clock);
		tchk <= 1'b0;
	endtask

	task automatic cmd(input i2clk_op_e c);
		int n;
		n = 0;
		bus_wr(HC_CMD, {5'h00, c});
		do begin
			bus_rd(HC_CMD, 1'b0, 8'h00);
			n++;
		end while (st[ST_BUSY] !== 1'b0 && n < 200);
		// Stuck controller counts as a mismatch
		if (st[ST_BUSY] !== 1'b0)
			miscompares++;
	endtask

	task automatic send(input logic [7:0] b, input logic nak);
		logic [7:0] e;
		e = 8'h00;
		e[ST_NAK] = nak;
		bus_wr(HC_TXDATA, b);
		cmd(OP_SEND);
		bus_rd(HC_CMD, 1'b1, e);
	endtask

	task automatic wr_regs(input logic [7:0] r, input int n);
		cmd(OP_START);
		send({TARGET_ADDR, 1'b0}, 1'b0);
		send(r, 1'b0);
		for (int i = 0; i < n; i++)
			send(wbuf[i], 1'b0);
		cmd(OP_STOP);
	endtask

	task automatic rd_regs(input logic [7:0] r, input int n);
		cmd(OP_START);
		send({TARGET_ADDR, 1'b0}, 1'b0);
		send(r, 1'b0);
		cmd(OP_START);
		send({TARGET_ADDR, 1'b1}, 1'b0);
		for (int i = 0; i < n; i++) begin
			cmd(i == n - 1 ? OP_RECV_NAK : OP_RECV_ACK);
			bus_rd(HC_RXDATA, 1'b1, ebuf[i]);
		end
		cmd(OP_STOP);
	endtask

	task automatic wr1(input logic [7:0] r, input logic [7:0] d);
		wbuf[0] = d;
		wr_regs(r, 1);
	endtask

	task automatic rd1(input logic [7:0] r, input logic [7:0] e);
		ebuf[0] = e;
		rd_regs(r, 1);
	endtask

	task automatic fill;
		for (int i = 0; i < 4; i++) begin
			wbuf[i] = lfsr;
			lfsr = next_rand(lfsr);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		note_tgt(1'b0, OTP_LK);
		ebuf = '{8'h0f, 8'h00, 8'h00, 8'h00};
		rd_regs(PW_A, 3);
		wr1(REG_FIXED, lfsr);
		rd1(REG_FIXED, OTP_FX);
		fill();
		wr_regs(8'h20, 3);
		ebuf = wbuf;
		rd_regs(8'h20, 3);
		fill();
		wr_regs(REG_ZERO, 2);
		ebuf = '{wbuf[1], wbuf[1], 8'h00, 8'h00};
		rd_regs(REG_ZERO, 2);
		wr1(PROT_BASE, ~OTP_DEF);
		rd1(PROT_BASE, OTP_DEF);
		wbuf = '{8'h00, 8'h00, 8'h00, 8'h00};
		wr_regs(MASK_A, 3);
		wbuf = '{8'h55, 8'h55, 8'h55, 8'h00};
		wr_regs(PW_A, 3);
		note_tgt(1'b0, 24'h000000);
		ebuf = '{8'h00, 8'h00, 8'h00, 8'h00};
		rd_regs(PW_A, 3);
		wr1(PROT_BASE, ~OTP_DEF);
		rd1(PROT_BASE, ~OTP_DEF);
		wr1(MASK_A, 8'hf0);
		wr1(PW_A, CODE_LOCK);
		note_tgt(1'b0, 24'h00000f);
		rd1(PW_A, 8'h0f);
		wr1(PW_A, 8'h33);
		note_tgt(1'b0, 24'h00000f);
		rd1(PW_A, 8'h0f);
		cmd(OP_START);
		send({TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1);
		cmd(OP_STOP);
		cmd(OP_START);
		note_tgt(1'b1, 24'h00000f);
		send({TARGET_ADDR, 1'b0}, 1'b0);
		send(LAST_REG + 8'h01, 1'b1);
		send(lfsr, 1'b1);
		bus_rd(HC_TXDATA, 1'b1, lfsr);
		cmd(OP_STOP);
		// Unknown op code is refused: no busy, nak kept
		bus_wr(HC_CMD, 8'h07);
		bus_rd(HC_CMD, 1'b1, 8'h02);
		close_out();
	end
endmodule
`default_nettype wire
